// [hw/pss_top.sv]
// protection switch status relays, override lines and register slave
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - falling edge on an override line forces switch to that line's input
// - primary relay active only while primary input is judged good
// - secondary relay active only while secondary input is judged good
// - position relay inactive on primary, active when secondary is selected
// - inactive status relay means failed, so power loss reads failed
// - in remote mode, remotely supplied values take precedence over front edge switches
// - in local mode parameters without a switch take fixed defaults
// - remote values held in own storage and in force again on return to remote mode
module pss_top
  import pss_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        force_primary_input_n,
  input  wire logic        force_secondary_input_n,
  input  wire logic        pri_judged_good,
  input  wire logic        sec_judged_good,
  input  wire logic        algo_sel_primary,
  input  wire logic        algo_sel_secondary,
  input  wire logic        remote_mode,
  input  wire logic        local_pid_switch,
  output logic             pri_status_relay,
  output logic             sec_status_relay,
  output logic             switch_pos_relay,
  output logic             sel_secondary,
  output pss_cfg_t         eff_cfg,
  output logic             irq
);

  typedef struct packed {
    logic                 aw_got;
    logic [7:0]           awaddr;
    logic                 w_got;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 sel_sec;
    logic                 pri_good;
    logic                 sec_good;
    logic [PSS_IRQ_W-1:0] ist;
    logic [PSS_IRQ_W-1:0] imask;
    logic                 irq;
    logic                 cfg_valid;
    pss_cfg_t             rcfg;
    logic                 pri_rel;
    logic                 sec_rel;
    logic                 pos_rel;
  } pss_top_st_t;

  // whole block state in one record
  pss_top_st_t q;
  pss_top_st_t d;

  // override pulses and parameter set in force
  logic     ovr_pri;
  logic     ovr_sec;
  pss_cfg_t cfg_now;

  // one pulse per falling edge on each override line
  pss_fall_det u_fd_pri (
    .core_clk (core_clk),
    .resetn   (resetn),
    .line_n   (force_primary_input_n),
    .fall     (ovr_pri)
  );

  pss_fall_det u_fd_sec (
    .core_clk (core_clk),
    .resetn   (resetn),
    .line_n   (force_secondary_input_n),
    .fall     (ovr_sec)
  );

  // parameter set in force
  pss_cfg_sel u_cfg (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .remote_mode      (remote_mode),
    .remote_valid     (q.cfg_valid),
    .remote_cfg       (q.rcfg),
    .local_pid_switch (local_pid_switch),
    .eff_cfg          (cfg_now)
  );

  // register read view
  function automatic logic [31:0] reg_rd(input logic [7:0] a, input pss_top_st_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      PSS_STAT_OFS: begin
        v[PSS_STAT_PRIGOOD] = s.pri_good;
        v[PSS_STAT_SECGOOD] = s.sec_good;
        v[PSS_STAT_POS]     = s.sel_sec;
        v[PSS_STAT_REMOTE]  = remote_mode;
        v[PSS_STAT_CFGVAL]  = s.cfg_valid;
      end
      PSS_IST_OFS:   v[PSS_IRQ_W-1:0] = s.ist;
      PSS_IMASK_OFS: v[PSS_IRQ_W-1:0] = s.imask;
      PSS_CFG0_OFS: begin
        v[PSS_C0_AUTORST]                 = s.rcfg.auto_reset;
        v[PSS_C0_SECTEST]                 = s.rcfg.sec_test_en;
        v[PSS_C0_ASITEST +: 2]            = s.rcfg.asi_test;
        v[PSS_C0_GPIMODE +: 2]            = s.rcfg.gpi_mode;
        v[PSS_C0_PGMTGT +: 3]             = s.rcfg.pgm_target;
        v[PSS_C0_RSTTIME +: 6]            = s.rcfg.reset_time;
      end
      PSS_CFG1_OFS: v[PSS_C1_ASITIME +: 12] = s.rcfg.asi_time;
      PSS_CFG2_OFS: begin
        v[PSS_C2_MINVID +: 14] = s.rcfg.min_vid;
        v[PSS_C2_MINAUD +: 14] = s.rcfg.min_aud;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_rd

  // mapped offsets answer okay, the rest slave error
  function automatic logic reg_hit(input logic [7:0] a);
    return (a == PSS_CTRL_OFS) || (a == PSS_STAT_OFS) || (a == PSS_IST_OFS) ||
           (a == PSS_IMASK_OFS) || (a == PSS_CFG0_OFS) || (a == PSS_CFG1_OFS) ||
           (a == PSS_CFG2_OFS);
  endfunction : reg_hit

  // write merge and command helpers
  logic [31:0] wmask;
  logic [31:0] wmerge;
  logic        wr_go;
  logic        sw_pri;
  logic        sw_sec;
  logic        new_sec;
  logic        ovr_act;

  always_comb begin
    d       = q;
    wmask   = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    wmerge  = (reg_rd(q.awaddr, q) & ~wmask) | (q.wdata & wmask);
    wr_go   = q.aw_got && q.w_got && !q.bvalid;
    sw_pri  = 1'b0;
    sw_sec  = 1'b0;
    new_sec = q.sel_sec;
    ovr_act = (cfg_now.gpi_mode == PSS_GPI_NEGEDGE);

    // write address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // interrupt status clears first so a same cycle event sets it again
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = reg_hit(q.awaddr) ? PSS_RESP_OKAY : PSS_RESP_SLVERR;
      case (q.awaddr)
        PSS_CTRL_OFS: begin
          sw_pri = q.wdata[PSS_CTRL_SELPRI] & q.wstrb[0];
          sw_sec = q.wdata[PSS_CTRL_SELSEC] & q.wstrb[0];
        end
        PSS_IST_OFS:   d.ist   = q.ist & ~(q.wdata[PSS_IRQ_W-1:0] & wmask[PSS_IRQ_W-1:0]);
        PSS_IMASK_OFS: d.imask = wmerge[PSS_IRQ_W-1:0];
        PSS_CFG0_OFS: begin
          d.rcfg.auto_reset  = wmerge[PSS_C0_AUTORST];
          d.rcfg.sec_test_en = wmerge[PSS_C0_SECTEST];
          d.rcfg.asi_test    = pss_test_t'(wmerge[PSS_C0_ASITEST +: 2]);
          d.rcfg.gpi_mode    = pss_gpi_t'(wmerge[PSS_C0_GPIMODE +: 2]);
          d.rcfg.pgm_target  = wmerge[PSS_C0_PGMTGT +: 3];
          d.rcfg.reset_time  = wmerge[PSS_C0_RSTTIME +: 6];
          d.cfg_valid        = 1'b1;
        end
        PSS_CFG1_OFS: begin
          d.rcfg.asi_time = wmerge[PSS_C1_ASITIME +: 12];
          d.cfg_valid     = 1'b1;
        end
        PSS_CFG2_OFS: begin
          d.rcfg.min_vid = wmerge[PSS_C2_MINVID +: 14];
          d.rcfg.min_aud = wmerge[PSS_C2_MINAUD +: 14];
          d.cfg_valid    = 1'b1;
        end
        default: begin
          // unmapped and read-only offsets change nothing
        end
      endcase
    end
    // ready again once the response is taken
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;

    // read channel, one outstanding
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = reg_rd(s_axi_araddr, q);
      d.rresp  = reg_hit(s_axi_araddr) ? PSS_RESP_OKAY : PSS_RESP_SLVERR;
    end
    d.arready = !d.rvalid;

    // switch position: override lines, then software, then algorithm
    if (ovr_act && ovr_pri) begin
      new_sec = 1'b0;
    end else if (ovr_act && ovr_sec) begin
      new_sec = 1'b1;
    end else if (sw_pri) begin
      new_sec = 1'b0;
    end else if (sw_sec) begin
      new_sec = 1'b1;
    end else if (algo_sel_primary) begin
      new_sec = 1'b0;
    end else if (algo_sel_secondary) begin
      new_sec = 1'b1;
    end
    // judged inputs registered once before the relays
    d.sel_sec  = new_sec;
    d.pri_good = pri_judged_good;
    d.sec_good = sec_judged_good;

    // status relays follow judged state; released means failed
    d.pri_rel = q.pri_good;
    d.sec_rel = q.sec_good;
    d.pos_rel = q.sel_sec;

    // sticky events
    if (ovr_act && ovr_pri) d.ist[PSS_IRQ_OVRPRI] = 1'b1;
    if (ovr_act && ovr_sec) d.ist[PSS_IRQ_OVRSEC] = 1'b1;
    if (d.pri_good != q.pri_good) d.ist[PSS_IRQ_PRICHG] = 1'b1;
    if (d.sec_good != q.sec_good) d.ist[PSS_IRQ_SECCHG] = 1'b1;
    if (new_sec != q.sel_sec) d.ist[PSS_IRQ_POSCHG] = 1'b1;
    // level interrupt, one cycle behind the status bits
    d.irq = |(q.ist & q.imask);
  end

  // state register; remote values survive until reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q           <= '0;
      q.awready   <= 1'b1;
      q.wready    <= 1'b1;
      q.arready   <= 1'b1;
      q.rcfg      <= PSS_CFG_DEFAULT;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign s_axi_awready    = q.awready;
  assign s_axi_wready     = q.wready;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_arready    = q.arready;
  assign s_axi_rdata      = q.rdata;
  assign s_axi_rresp      = q.rresp;
  assign s_axi_rvalid     = q.rvalid;
  assign pri_status_relay = q.pri_rel;
  assign sec_status_relay = q.sec_rel;
  assign switch_pos_relay = q.pos_rel;
  assign sel_secondary    = q.sel_sec;
  assign eff_cfg          = cfg_now;
  assign irq              = q.irq;

endmodule : pss_top
`default_nettype wire

// [hw/pss_pkg.sv]
// shared constants and types for the protection switch status and control block
package pss_pkg;

  // register byte offsets
  localparam logic [7:0] PSS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PSS_STAT_OFS   = 8'h04;
  localparam logic [7:0] PSS_IST_OFS    = 8'h08;
  localparam logic [7:0] PSS_IMASK_OFS  = 8'h0c;
  localparam logic [7:0] PSS_CFG0_OFS   = 8'h10;
  localparam logic [7:0] PSS_CFG1_OFS   = 8'h14;
  localparam logic [7:0] PSS_CFG2_OFS   = 8'h18;

  // control register bits (write one to act)
  localparam int PSS_CTRL_SELPRI = 0;
  localparam int PSS_CTRL_SELSEC = 1;

  // status register bits
  localparam int PSS_STAT_PRIGOOD = 0;
  localparam int PSS_STAT_SECGOOD = 1;
  localparam int PSS_STAT_POS     = 2;
  localparam int PSS_STAT_REMOTE  = 3;
  localparam int PSS_STAT_CFGVAL  = 4;

  // interrupt status and mask bits
  localparam int PSS_IRQ_W        = 5;
  localparam int PSS_IRQ_OVRPRI   = 0;
  localparam int PSS_IRQ_OVRSEC   = 1;
  localparam int PSS_IRQ_PRICHG   = 2;
  localparam int PSS_IRQ_SECCHG   = 3;
  localparam int PSS_IRQ_POSCHG   = 4;

  // configuration field positions
  localparam int PSS_C0_AUTORST = 0;
  localparam int PSS_C0_SECTEST = 1;
  localparam int PSS_C0_ASITEST = 2;
  localparam int PSS_C0_GPIMODE = 4;
  localparam int PSS_C0_PGMTGT  = 6;
  localparam int PSS_C0_RSTTIME = 16;
  localparam int PSS_C1_ASITIME = 0;
  localparam int PSS_C2_MINVID  = 0;
  localparam int PSS_C2_MINAUD  = 16;

  // stream test levels
  typedef enum logic [1:0] {
    PSS_TEST_OFF    = 2'b00,
    PSS_TEST_SIMPLE = 2'b01,
    PSS_TEST_ADV    = 2'b10
  } pss_test_t;

  // override line modes
  typedef enum logic [1:0] {
    PSS_GPI_OFF     = 2'b00,
    PSS_GPI_NEGEDGE = 2'b01,
    PSS_GPI_EXTFLT  = 2'b10,
    PSS_GPI_EXTINH  = 2'b11
  } pss_gpi_t;

  // parameter set in force
  typedef struct packed {
    logic        auto_reset;
    logic        sec_test_en;
    pss_test_t   asi_test;
    pss_gpi_t    gpi_mode;
    logic [2:0]  pgm_target;  // 0 any, 1..4 program
    logic [5:0]  reset_time;  // seconds
    logic [11:0] asi_time;    // tenths of a second
    logic [13:0] min_vid;
    logic [13:0] min_aud;
  } pss_cfg_t;

  // fixed defaults, also the local values of parameters with no switch
  localparam pss_cfg_t PSS_CFG_DEFAULT = '{
    auto_reset:  1'b1,
    sec_test_en: 1'b1,
    asi_test:    PSS_TEST_SIMPLE,
    gpi_mode:    PSS_GPI_NEGEDGE,
    pgm_target:  3'h0,
    reset_time:  6'h0f,
    asi_time:    12'h014,
    min_vid:     14'h0064,
    min_aud:     14'h0014
  };

  localparam logic [1:0] PSS_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PSS_RESP_SLVERR = 2'b10;

endpackage : pss_pkg

// [hw/pss_fall_det.sv]
// override line synchroniser with falling edge pulse
`timescale 1ns/100ps
`default_nettype none
module pss_fall_det
  import pss_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic line_n,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic fall;
  } pss_fd_st_t;

  pss_fd_st_t q;
  pss_fd_st_t d;

  // two stage sync, edge seen between second and third stage
  always_comb begin
    d      = q;
    d.s1   = line_n;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.fall = q.s3 & ~q.s2;
  end

  // idle line is high, so reset to high
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, fall: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign fall = q.fall;

endmodule : pss_fall_det
`default_nettype wire

// [hw/pss_cfg_sel.sv]
// picks remote or local parameter set
`timescale 1ns/100ps
`default_nettype none
module pss_cfg_sel
  import pss_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     resetn,
  input  wire logic     remote_mode,
  input  wire logic     remote_valid,
  input  wire pss_cfg_t remote_cfg,
  input  wire logic     local_pid_switch,
  output pss_cfg_t      eff_cfg
);

  typedef struct packed {
    pss_cfg_t cfg;
  } pss_cs_st_t;

  pss_cs_st_t q;
  pss_cs_st_t d;

  // remote values win in remote mode once supplied, else defaults plus the front switch
  always_comb begin
    d = q;
    if (remote_mode && remote_valid) begin
      d.cfg = remote_cfg;
    end else begin
      d.cfg          = PSS_CFG_DEFAULT;
      d.cfg.asi_test = local_pid_switch ? PSS_TEST_ADV : PSS_TEST_SIMPLE;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{cfg: PSS_CFG_DEFAULT};
    end else begin
      q <= d;
    end
  end

  assign eff_cfg = q.cfg;

endmodule : pss_cfg_sel
`default_nettype wire

// [verif/pss_top_assertions.sv]
// concurrent checks on the relay outputs, override lines and parameter set
`timescale 1ns/100ps
`default_nettype none
module pss_top_checker
  import pss_pkg::*;
(
  input wire logic     core_clk,
  input wire logic     resetn,
  input wire logic     force_primary_input_n,
  input wire logic     force_secondary_input_n,
  input wire logic     pri_judged_good,
  input wire logic     sec_judged_good,
  input wire logic     algo_sel_secondary,
  input wire logic     s_axi_wvalid,
  input wire logic     remote_mode,
  input wire logic     local_pid_switch,
  input wire logic     pri_status_relay,
  input wire logic     sec_status_relay,
  input wire logic     switch_pos_relay,
  input wire logic     sel_secondary,
  input wire pss_cfg_t eff_cfg
);
  pss_cfg_t loc_cfg;
  logic     neg_mode;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // expected local set: defaults with the test level from the front switch
  always_comb begin
    loc_cfg          = PSS_CFG_DEFAULT;
    loc_cfg.asi_test = local_pid_switch ? PSS_TEST_ADV : PSS_TEST_SIMPLE;
  end
  assign neg_mode = (eff_cfg.gpi_mode == PSS_GPI_NEGEDGE);

  a_pri_good_on: assert property (pri_judged_good [*3] |-> pri_status_relay)
    else $error("primary relay not active while input good");
  a_pri_fail_off: assert property (!pri_judged_good [*3] |-> !pri_status_relay)
    else $error("primary relay active while input failed");
  a_sec_good_on: assert property (sec_judged_good [*3] |-> sec_status_relay)
    else $error("secondary relay not active while input good");
  a_sec_fail_off: assert property (!sec_judged_good [*3] |-> !sec_status_relay)
    else $error("secondary relay active while input failed");
  a_pos_relay_tracks: assert property ($stable(sel_secondary)
      |-> switch_pos_relay == sel_secondary)
    else $error("position relay disagrees with selection");
  a_ovr_to_sec: assert property ($fell(force_secondary_input_n) && force_primary_input_n
      && neg_mode && !sel_secondary |-> ##[3:4] sel_secondary)
    else $error("secondary override edge not obeyed");
  a_ovr_to_pri: assert property ($fell(force_primary_input_n) && neg_mode && sel_secondary
      |-> ##[3:4] !sel_secondary)
    else $error("primary override edge not obeyed");
  a_ovr_sync_delay: assert property ($fell(force_secondary_input_n) && !sel_secondary
      && !algo_sel_secondary && !s_axi_wvalid |=> !sel_secondary)
    else $error("override acted before synchronisation");
  a_local_cfg: assert property (!remote_mode && !$past(remote_mode) && $stable(local_pid_switch)
      |-> eff_cfg == loc_cfg)
    else $error("local parameter set wrong");
endmodule : pss_top_checker

bind pss_top pss_top_checker u_chk (
  .core_clk, .resetn, .force_primary_input_n, .force_secondary_input_n,
  .pri_judged_good, .sec_judged_good, .algo_sel_secondary, .s_axi_wvalid,
  .remote_mode, .local_pid_switch, .pri_status_relay, .sec_status_relay,
  .switch_pos_relay, .sel_secondary, .eff_cfg
);
`default_nettype wire

// [verif/pss_alarm_model.sv]
// alarm system stand-in: override contacts and relay contact view
`timescale 1ns/100ps
`default_nettype none
module pss_alarm_model (
  input  wire logic close_pri,
  input  wire logic close_sec,
  input  wire logic pri_status_relay,
  input  wire logic sec_status_relay,
  input  wire logic switch_pos_relay,
  output logic      force_primary_input_n,
  output logic      force_secondary_input_n,
  output logic [2:0] no_closed
);
  // closed contact grounds the line, pull-up holds it high when open
  assign force_primary_input_n   = !close_pri;
  assign force_secondary_input_n = !close_sec;
  // normally-open contacts on common while a relay is active
  assign no_closed = {switch_pos_relay, sec_status_relay, pri_status_relay};
endmodule : pss_alarm_model
`default_nettype wire

// [verif/protection_switch_status_control_test.sv]
// register-level bench for the protection switch status block
`timescale 1ns/100ps
`default_nettype none
module protection_switch_status_control_test
  import pss_pkg::*;
;
  logic        core_clk, resetn, close_pri, close_sec, fp_n, fs_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        pri_judged_good, sec_judged_good, algo_sel_primary, algo_sel_secondary;
  logic        remote_mode, local_pid_switch, pri_status_relay, sec_status_relay;
  logic        switch_pos_relay, sel_secondary, irq;
  logic [2:0]  no_closed;
  pss_cfg_t    eff_cfg;
  int          compares, miscompares;

  pss_top DUT (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .force_primary_input_n(fp_n),
    .force_secondary_input_n(fs_n), .pri_judged_good, .sec_judged_good, .algo_sel_primary,
    .algo_sel_secondary, .remote_mode, .local_pid_switch, .pri_status_relay,
    .sec_status_relay, .switch_pos_relay, .sel_secondary, .eff_cfg, .irq);

  pss_alarm_model u_model (.close_pri, .close_sec, .pri_status_relay, .sec_status_relay,
    .switch_pos_relay, .force_primary_input_n(fp_n), .force_secondary_input_n(fs_n),
    .no_closed);

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string n, input logic [63:0] got, input logic [63:0] want);
    compares++;
    if (got !== want) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, want, got);
    end
  endtask : chk

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // close contacts {sec,pri} for 4 cycles, then settle
  task automatic press(input logic [1:0] l);
    {close_sec, close_pri} <= l;
    repeat (4) @(posedge core_clk);
    {close_sec, close_pri} <= 2'b00;
    repeat (5) @(posedge core_clk);
  endtask : press

  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    final_report();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    pss_cfg_t    lc;
    pss_cfg_t    rc;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, close_pri, close_sec} = '0;
    {pri_judged_good, sec_judged_good, algo_sel_primary, algo_sel_secondary} = '0;
    {remote_mode, local_pid_switch, resetn} = '0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge core_clk);
    chk("reset relays", 64'(no_closed), 64'(0));
    chk("reset cfg", 64'(eff_cfg), 64'(PSS_CFG_DEFAULT));
    resetn <= 1'b1;
    // relays and status follow each judged combination
    for (int i = 0; i < 4; i++) begin
      pri_judged_good <= i[0];
      sec_judged_good <= i[1];
      repeat (3) @(posedge core_clk);
      chk("relays", 64'(no_closed[1:0]), 64'(i[1:0]));
      rd(PSS_STAT_OFS, d, r);
      chk("stat good", 64'(d[1:0]), 64'(i[1:0]));
    end
    // override edges, interrupt raise, clear and mask
    wr(PSS_IMASK_OFS, 32'h2, r);
    press(2'b10);
    chk("to sec", 64'({sel_secondary, no_closed[2]}), 64'(3));
    chk("irq set", 64'(irq), 64'(1));
    wr(PSS_IST_OFS, 32'h2, r);
    repeat (2) @(posedge core_clk);
    chk("irq clear", 64'(irq), 64'(0));
    press(2'b01);
    chk("to pri", 64'({sel_secondary, no_closed[2]}), 64'(0));
    chk("irq masked", 64'(irq), 64'(0));
    rd(PSS_IST_OFS, d, r);
    chk("ist ovr", 64'(d[1:0]), 64'(1));
    // both lines at once: primary wins
    wr(PSS_CTRL_OFS, 32'h2, r);
    repeat (3) @(posedge core_clk);
    chk("ctrl sec", 64'(sel_secondary), 64'(1));
    press(2'b11);
    chk("both", 64'(sel_secondary), 64'(0));
    // a held line gives a single command
    close_sec <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("held sec", 64'(sel_secondary), 64'(1));
    wr(PSS_CTRL_OFS, 32'h1, r);
    repeat (8) @(posedge core_clk);
    chk("held once", 64'(sel_secondary), 64'(0));
    close_sec <= 1'b0;
    algo_sel_secondary <= 1'b1;
    @(posedge core_clk);
    algo_sel_secondary <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("algo sec", 64'({sel_secondary, no_closed[2]}), 64'(3));
    algo_sel_primary <= 1'b1;
    @(posedge core_clk);
    algo_sel_primary <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("algo pri", 64'({sel_secondary, no_closed[2]}), 64'(0));
    // local set, then remote set kept across mode changes
    lc = PSS_CFG_DEFAULT;
    lc.asi_test = PSS_TEST_ADV;
    rc = PSS_CFG_DEFAULT;
    rc.asi_time = 12'h064;
    local_pid_switch <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("local cfg", 64'(eff_cfg), 64'(lc));
    remote_mode <= 1'b1;
    wr(PSS_CFG1_OFS, 32'h64, r);
    repeat (2) @(posedge core_clk);
    chk("remote cfg", 64'(eff_cfg), 64'(rc));
    remote_mode <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("back local", 64'(eff_cfg), 64'(lc));
    remote_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("kept remote", 64'(eff_cfg), 64'(rc));
    rd(PSS_CFG1_OFS, d, r);
    chk("cfg1 rd", 64'({r, d}), 64'({PSS_RESP_OKAY, 32'h0000_0064}));
    // remote override mode off: edges ignored
    wr(PSS_CFG0_OFS, 32'h000f0007, r);
    press(2'b10);
    chk("gpi off", 64'(sel_secondary), 64'(0));
    rd(PSS_CFG0_OFS, d, r);
    chk("cfg0 rd", 64'(d), 64'(32'h000f_0007));
    // refused and ignored accesses
    rd(8'h1c, d, r);
    chk("unmapped rd", 64'({r, d}), 64'({PSS_RESP_SLVERR, 32'h0}));
    wr(8'h1c, 32'h1, r);
    chk("unmapped wr", 64'(r), 64'(PSS_RESP_SLVERR));
    wr(PSS_STAT_OFS, 32'h1f, r);
    rd(PSS_STAT_OFS, d, r);
    chk("stat ro", 64'(d[2:0]), 64'(3));
    final_report();
  end
endmodule : protection_switch_status_control_test
`default_nettype wire
